// ===== ddc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl #(
    parameter int          SAMPLE_W     = 14,
    parameter logic [7:0]  REVISION_ID  = 8'h01
) (
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire logic                ce,
    input  wire logic                sclk,
    input  wire logic                cs_n,
    input  wire logic                sdio_in,
    output logic                     sdio_out,
    output logic                     sdio_oe,
    input  wire logic                sample_bus_clock,
    input  wire logic [SAMPLE_W-1:0] sample_bus,
    input  wire logic                converter_clock,
    output logic [SAMPLE_W-1:0]      i_sample_r,
    output logic [SAMPLE_W-1:0]      q_sample_r,
    output logic                     sample_valid_r,
    output logic [1:0]               i_phase_used_r,
    output logic [1:0]               q_phase_used_r,
    output logic                     searching_r
);
    if (SAMPLE_W < 8 || SAMPLE_W > 14)
    begin : g_width_check
        $error("SAMPLE_W must lie between 8 and 14");
    end

    typedef enum logic [2:0] {
        IDLE   = 3'b001,
        SEARCH = 3'b010,
        CALIB  = 3'b100
    } ddc_state_t;

    ddc_pkg::ddc_reg_req_t req;
    logic [7:0]          rdata;

    ddc_serial_port u_port (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .sclk     (sclk),
        .cs_n     (cs_n),
        .sdio_in  (sdio_in),
        .sdio_out (sdio_out),
        .sdio_oe  (sdio_oe),
        .req      (req),
        .rdata    (rdata)
    );

    function automatic logic hit(input logic [4:0] ofs);
        hit = req.wr && (req.addr == ofs);
    endfunction

    // Registers.
    logic [7:0] data_ctrl_r;
    logic [5:0] mem_loc_r;
    logic [5:0] mem_word_r;
    logic       i_done_r;
    logic       q_done_r;
    logic [1:0] i_coef_state_r;
    logic [1:0] q_coef_state_r;
    logic       override_r;
    logic       reacquire_r;
    logic [1:0] i_force_r;
    logic [1:0] i_found_r;
    logic [1:0] q_found_r;
    logic [5:0] coef_mem [ddc_pkg::COEF_DEPTH];

    ddc_state_t state_r;
    logic [7:0] cnt_r;
    logic       cal_start;
    logic       reacq_rise;
    logic       cal_end;

    // A start outside idle is ignored whole, so it cannot clear done bits it never sets again.
    assign cal_start  = hit(ddc_pkg::OFS_MEM_CMD) && req.wdata[ddc_pkg::BIT_CAL_START]
                        && (state_r == IDLE);
    assign reacq_rise = hit(ddc_pkg::OFS_PHASE) && req.wdata[ddc_pkg::BIT_REACQUIRE]
                        && !reacquire_r;
    assign cal_end    = (state_r == CALIB) && (cnt_r == 8'(ddc_pkg::SELF_CAL_CYC - 1));

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            data_ctrl_r <= 8'h00;
            mem_loc_r   <= 6'h00;
        end
        else if (ce)
        begin
            if (hit(ddc_pkg::OFS_DATA_CTRL))
                data_ctrl_r <= req.wdata;
            if (hit(ddc_pkg::OFS_MEM_LOC))
                mem_loc_r <= req.wdata[5:0];
        end
    end

    // Command bits are never stored, so every strobe reads back as zero.
    always_ff @(posedge ref_clk)
    begin
        if (ce && hit(ddc_pkg::OFS_MEM_CMD))
        begin
            for (int k = 0; k < ddc_pkg::COEF_DEPTH; k++)
            begin
                if (k < ddc_pkg::COEF_HALF && req.wdata[ddc_pkg::BIT_I_DEFAULT])
                    coef_mem[k] <= ddc_pkg::COEF_RESET_WORD;
                if (k >= ddc_pkg::COEF_HALF && req.wdata[ddc_pkg::BIT_Q_DEFAULT])
                    coef_mem[k] <= ddc_pkg::COEF_RESET_WORD;
            end
            if (req.wdata[ddc_pkg::BIT_MEM_WRITE])
                coef_mem[mem_loc_r] <= mem_word_r;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            mem_word_r <= 6'h00;
        else if (ce)
        begin
            if (hit(ddc_pkg::OFS_MEM_CMD) && req.wdata[ddc_pkg::BIT_MEM_READ])
                mem_word_r <= coef_mem[mem_loc_r];
            else if (hit(ddc_pkg::OFS_MEM_WORD))
                mem_word_r <= req.wdata[5:0];
        end
    end

    // Calibration status; completion wins over a clear in the same cycle.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            i_done_r       <= 1'b0;
            q_done_r       <= 1'b0;
            i_coef_state_r <= ddc_pkg::COEF_UNCAL;
            q_coef_state_r <= ddc_pkg::COEF_UNCAL;
        end
        else if (ce)
        begin
            if (cal_end)
            begin
                i_done_r       <= 1'b1;
                q_done_r       <= 1'b1;
                i_coef_state_r <= ddc_pkg::COEF_SELF;
                q_coef_state_r <= ddc_pkg::COEF_SELF;
            end
            else if (hit(ddc_pkg::OFS_MEM_CMD))
            begin
                if (req.wdata[ddc_pkg::BIT_I_CLEAR] || cal_start)
                    i_done_r <= 1'b0;
                if (req.wdata[ddc_pkg::BIT_Q_CLEAR] || cal_start)
                    q_done_r <= 1'b0;
                if (req.wdata[ddc_pkg::BIT_MEM_WRITE])
                begin
                    if (mem_loc_r < 6'(ddc_pkg::COEF_HALF))
                        i_coef_state_r <= ddc_pkg::COEF_USER;
                    else
                        q_coef_state_r <= ddc_pkg::COEF_USER;
                end
                if (req.wdata[ddc_pkg::BIT_I_DEFAULT])
                    i_coef_state_r <= ddc_pkg::COEF_UNCAL;
                if (req.wdata[ddc_pkg::BIT_Q_DEFAULT])
                    q_coef_state_r <= ddc_pkg::COEF_UNCAL;
            end
        end
    end

    // Phase control register.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            override_r  <= 1'b0;
            reacquire_r <= 1'b0;
            i_force_r   <= 2'h0;
        end
        else if (ce && hit(ddc_pkg::OFS_PHASE))
        begin
            override_r  <= req.wdata[ddc_pkg::BIT_OVERRIDE];
            reacquire_r <= req.wdata[ddc_pkg::BIT_REACQUIRE];
            // A written Q field is dropped: the forced I phase drives both retimers.
            if (req.wdata[ddc_pkg::BIT_OVERRIDE])
                i_force_r <= req.wdata[ddc_pkg::POS_I_PHASE +: 2];
        end
    end

    // Link and converter clocks are sampled by ref_clk through two flops.
    logic [1:0]          lclk_s_r;
    logic [1:0]          cclk_s_r;
    logic [SAMPLE_W-1:0] bus_s1_r;
    logic [SAMPLE_W-1:0] bus_s2_r;
    logic                lclk_d_r;
    logic                cclk_d_r;
    logic                l_rise;
    logic                l_fall;
    logic                c_rise;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lclk_s_r <= 2'h0;
            cclk_s_r <= 2'h0;
            bus_s1_r <= '0;
            bus_s2_r <= '0;
            lclk_d_r <= 1'b0;
            cclk_d_r <= 1'b0;
        end
        else if (ce)
        begin
            lclk_s_r <= {lclk_s_r[0], sample_bus_clock};
            cclk_s_r <= {cclk_s_r[0], converter_clock};
            bus_s1_r <= sample_bus;
            bus_s2_r <= bus_s1_r;
            lclk_d_r <= lclk_s_r[1];
            cclk_d_r <= cclk_s_r[1];
        end
    end

    assign l_rise = lclk_s_r[1] && !lclk_d_r;
    assign l_fall = !lclk_s_r[1] && lclk_d_r;
    assign c_rise = cclk_s_r[1] && !cclk_d_r;

    // Phase search: time the converter edge against the link clock period.
    logic [7:0] since_l_r;
    logic [7:0] period_r;
    logic [9:0] delta_x4;
    logic [1:0] quadrant;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            since_l_r <= 8'h00;
            period_r  <= 8'h00;
        end
        else if (ce)
        begin
            if (l_rise)
            begin
                since_l_r <= 8'h00;
                period_r  <= since_l_r + 8'h01;
            end
            else if (since_l_r != 8'hFF)
                since_l_r <= since_l_r + 8'h01;
        end
    end

    assign delta_x4 = {since_l_r, 2'b00};
    always_comb
    begin
        if (delta_x4 < {2'b00, period_r})
            quadrant = 2'h0;
        else if (delta_x4 < {1'b0, period_r, 1'b0})
            quadrant = 2'h1;
        else if (delta_x4 < ({1'b0, period_r, 1'b0} + {2'b00, period_r}))
            quadrant = 2'h2;
        else
            quadrant = 2'h3;
    end

    // A search ends on a measured edge or at the limit, whichever is first.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r     <= SEARCH;
            cnt_r       <= 8'h00;
            searching_r <= 1'b1;
            i_found_r   <= 2'h0;
            q_found_r   <= 2'h0;
        end
        else if (ce)
        begin
            unique case (state_r)
                IDLE:
                begin
                    cnt_r <= 8'h00;
                    if (reacq_rise)
                    begin
                        state_r     <= SEARCH;
                        searching_r <= 1'b1;
                    end
                    else if (cal_start)
                        state_r <= CALIB;
                end
                SEARCH:
                begin
                    cnt_r <= cnt_r + 8'h01;
                    if ((c_rise && period_r != 8'h00 && cnt_r > 8'h10)
                        || cnt_r == 8'(ddc_pkg::SEARCH_LIMIT_CYC - 2))
                    begin
                        i_found_r   <= quadrant;
                        q_found_r   <= quadrant;
                        searching_r <= 1'b0;
                        state_r     <= IDLE;
                    end
                end
                CALIB:
                begin
                    cnt_r <= cnt_r + 8'h01;
                    if (cal_end)
                        state_r <= IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            i_phase_used_r <= 2'h0;
            q_phase_used_r <= 2'h0;
        end
        else if (ce)
        begin
            i_phase_used_r <= override_r ? i_force_r : i_found_r;
            q_phase_used_r <= override_r ? i_force_r : q_found_r;
        end
    end

    // Sample port: I on the chosen edge, Q on the other, pair out after the second.
    logic                i_edge;
    logic                q_edge;
    logic [SAMPLE_W-1:0] i_hold_r;
    logic [SAMPLE_W-1:0] q_hold_r;
    logic [SAMPLE_W-1:0] fmt_mask;

    assign i_edge   = data_ctrl_r[ddc_pkg::BIT_I_RISING] ? l_rise : l_fall;
    assign q_edge   = data_ctrl_r[ddc_pkg::BIT_I_RISING] ? l_fall : l_rise;
    // Unsigned input is turned into twos complement by flipping the top bit.
    assign fmt_mask = data_ctrl_r[ddc_pkg::BIT_TWOS] ? '0 : {1'b1, {(SAMPLE_W-1){1'b0}}};

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            i_hold_r       <= '0;
            q_hold_r       <= '0;
            i_sample_r     <= '0;
            q_sample_r     <= '0;
            sample_valid_r <= 1'b0;
        end
        else if (ce)
        begin
            sample_valid_r <= 1'b0;
            if (i_edge)
                i_hold_r <= bus_s2_r ^ fmt_mask;
            if (q_edge)
                q_hold_r <= bus_s2_r ^ fmt_mask;
            if (data_ctrl_r[ddc_pkg::BIT_I_LEADS] ? q_edge : i_edge)
            begin
                i_sample_r     <= i_edge ? (bus_s2_r ^ fmt_mask) : i_hold_r;
                q_sample_r     <= q_edge ? (bus_s2_r ^ fmt_mask) : q_hold_r;
                sample_valid_r <= 1'b1;
            end
        end
    end

    always_comb
    begin
        rdata = 8'h00;
        unique case (req.addr)
            ddc_pkg::OFS_DATA_CTRL:  rdata = data_ctrl_r;
            ddc_pkg::OFS_CAL_STATUS: rdata = {q_done_r, i_done_r, 2'b00,
                                              q_coef_state_r, i_coef_state_r};
            ddc_pkg::OFS_MEM_LOC:    rdata = {2'b00, mem_loc_r};
            ddc_pkg::OFS_MEM_WORD:   rdata = {2'b00, mem_word_r};
            ddc_pkg::OFS_PHASE:      rdata = {q_phase_used_r, 1'b0, searching_r, reacquire_r,
                                              override_r, i_phase_used_r};
            ddc_pkg::OFS_REVISION:   rdata = REVISION_ID;
            default:                 rdata = 8'h00;
        endcase
    end
endmodule
`default_nettype wire

// ===== ddc_pkg.sv
`default_nettype none
package ddc_pkg;

    localparam logic [4:0] OFS_DATA_CTRL  = 5'h02;
    localparam logic [4:0] OFS_CAL_STATUS = 5'h0F;
    localparam logic [4:0] OFS_MEM_LOC    = 5'h10;
    localparam logic [4:0] OFS_MEM_WORD   = 5'h11;
    localparam logic [4:0] OFS_MEM_CMD    = 5'h12;
    localparam logic [4:0] OFS_PHASE      = 5'h14;
    localparam logic [4:0] OFS_REVISION   = 5'h1F;

    localparam int BIT_Q_DONE      = 7;
    localparam int BIT_I_DONE      = 6;
    localparam int POS_Q_STATE     = 2;
    localparam int POS_I_STATE     = 0;
    localparam int BIT_Q_CLEAR     = 7;
    localparam int BIT_I_CLEAR     = 6;
    localparam int BIT_CAL_START   = 4;
    localparam int BIT_MEM_WRITE   = 3;
    localparam int BIT_MEM_READ    = 2;
    localparam int BIT_Q_DEFAULT   = 1;
    localparam int BIT_I_DEFAULT   = 0;
    localparam int POS_Q_PHASE     = 6;
    localparam int BIT_SEARCHING   = 4;
    localparam int BIT_REACQUIRE   = 3;
    localparam int BIT_OVERRIDE    = 2;
    localparam int POS_I_PHASE     = 0;
    localparam int BIT_TWOS        = 7;
    localparam int BIT_I_LEADS     = 5;
    localparam int BIT_I_RISING    = 4;

    localparam logic [1:0] COEF_UNCAL = 2'h0;
    localparam logic [1:0] COEF_SELF  = 2'h1;
    localparam logic [1:0] COEF_USER  = 2'h2;
    localparam logic [5:0] COEF_RESET_WORD = 6'h20;
    localparam int         COEF_DEPTH      = 64;
    localparam int         COEF_HALF       = 32;

    localparam int SEARCH_LIMIT_CYC = 128;
    localparam int SELF_CAL_CYC     = 64;
    localparam int SERIAL_FRAME_BITS = 16;

    typedef struct packed {
        logic       wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } ddc_reg_req_t;

endpackage
`default_nettype wire

// ===== ddc_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module ddc_serial_port (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 ce,
    input  wire logic                 sclk,
    input  wire logic                 cs_n,
    input  wire logic                 sdio_in,
    output logic                      sdio_out,
    output logic                      sdio_oe,
    output ddc_pkg::ddc_reg_req_t     req,
    input  wire logic [7:0]           rdata
);
    logic [1:0] sclk_s_r;
    logic [1:0] cs_s_r;
    logic [1:0] din_s_r;
    logic       sclk_d_r;
    logic [3:0] bit_cnt_r;
    logic [6:0] shift_r;
    logic       read_r;
    logic       load_r;
    logic [7:0] tx_r;
    logic       rise;
    logic       fall;
    logic       active;

    // Pins cross in through two flops; only the second stage feeds logic.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_s_r <= 2'h0;
            cs_s_r   <= 2'h3;
            din_s_r  <= 2'h0;
            sclk_d_r <= 1'b0;
        end
        else if (ce)
        begin
            sclk_s_r <= {sclk_s_r[0], sclk};
            cs_s_r   <= {cs_s_r[0], cs_n};
            din_s_r  <= {din_s_r[0], sdio_in};
            sclk_d_r <= sclk_s_r[1];
        end
    end

    assign active = !cs_s_r[1];
    assign rise   = active && sclk_s_r[1] && !sclk_d_r;
    assign fall   = active && !sclk_s_r[1] && sclk_d_r;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bit_cnt_r <= 4'h0;
            shift_r   <= 7'h00;
            read_r    <= 1'b0;
            load_r    <= 1'b0;
            req       <= '0;
        end
        else if (ce)
        begin
            req.wr <= 1'b0;
            load_r <= 1'b0;
            if (!active)
            begin
                bit_cnt_r <= 4'h0;
                read_r    <= 1'b0;
            end
            else if (rise)
            begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                shift_r   <= {shift_r[5:0], din_s_r[1]};
                if (bit_cnt_r == 4'h7)
                begin
                    read_r   <= shift_r[6];
                    load_r   <= shift_r[6];
                    req.addr <= {shift_r[3:0], din_s_r[1]};
                end
                if (bit_cnt_r == 4'hF && !read_r)
                begin
                    req.wr    <= 1'b1;
                    req.wdata <= {shift_r, din_s_r[1]};
                end
            end
        end
    end

    // Read data leaves on falling edges so the master samples on rising ones.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_r     <= 8'h00;
            sdio_out <= 1'b0;
            sdio_oe  <= 1'b0;
        end
        else if (ce)
        begin
            if (!active || !read_r)
            begin
                sdio_oe <= 1'b0;
            end
            else if (load_r)
            begin
                tx_r <= rdata;
            end
            else if (fall && bit_cnt_r >= 4'h8)
            begin
                sdio_oe  <= 1'b1;
                sdio_out <= tx_r[7];
                tx_r     <= {tx_r[6:0], 1'b0};
            end
        end
    end
endmodule
`default_nettype wire

// ===== ddc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl_asserts #(
    parameter int SAMPLE_W = 14
) (
    input wire logic                ref_clk,
    input wire logic                reset_n,
    input wire logic                ce,
    input wire logic                sclk,
    input wire logic                cs_n,
    input wire logic                sdio_in,
    input wire logic                sdio_out,
    input wire logic                sdio_oe,
    input wire logic                sample_bus_clock,
    input wire logic [SAMPLE_W-1:0] sample_bus,
    input wire logic                converter_clock,
    input wire logic [SAMPLE_W-1:0] i_sample_r,
    input wire logic [SAMPLE_W-1:0] q_sample_r,
    input wire logic                sample_valid_r,
    input wire logic [1:0]          i_phase_used_r,
    input wire logic [1:0]          q_phase_used_r,
    input wire logic                searching_r
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // Eight idle cycles leave room for the synchroniser delay of the last write.
    sequence s_quiet;
        cs_n [*8];
    endsequence
    sequence s_settled;
        !searching_r && !$past(searching_r) && !$past(searching_r, 2);
    endsequence

    property p_search_start;
        $rose(reset_n) |-> searching_r;
    endproperty
    a_search_start: assert property (p_search_start) else $error("no search");
    property p_search_end;
        $rose(reset_n) |-> ##[0:132] !searching_r;
    endproperty
    a_search_end: assert property (p_search_end) else $error("search long");
    property p_no_search;
        s_quiet |-> !$rose(searching_r);
    endproperty
    a_no_search: assert property (p_no_search) else $error("stray search");
    property p_phase_hold;
        s_quiet ##0 s_settled |-> $stable(i_phase_used_r) && $stable(q_phase_used_r);
    endproperty
    a_phase_hold: assert property (p_phase_hold) else $error("phase moved");
    property p_oe_off;
        s_quiet |-> !sdio_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("sdio driven");
    property p_valid_gap;
        sample_valid_r |=> !sample_valid_r [*3];
    endproperty
    a_valid_gap: assert property (p_valid_gap) else $error("pair pulse");
    property p_hold;
        !sample_valid_r |-> $stable(i_sample_r) && $stable(q_sample_r);
    endproperty
    a_hold: assert property (p_hold) else $error("sample moved");
    property p_cause;
        sample_valid_r |-> $past(sample_bus_clock, 3) != $past(sample_bus_clock, 4);
    endproperty
    a_cause: assert property (p_cause) else $error("pulse no edge");
endmodule

bind ddc_ctrl ddc_ctrl_asserts #(.SAMPLE_W(SAMPLE_W)) u_chk (
    .ref_clk, .reset_n, .ce, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe,
    .sample_bus_clock, .sample_bus, .converter_clock, .i_sample_r,
    .q_sample_r, .sample_valid_r, .i_phase_used_r, .q_phase_used_r, .searching_r
);
`default_nettype wire

// ===== ddc_link_src.sv
`timescale 1ns/1ps
`default_nettype none
module ddc_link_src #(
    parameter int SAMPLE_W = 14
) (
    output logic                clk_o,
    output logic [SAMPLE_W-1:0] bus_o
);
    initial
    begin
        clk_o = 1'b0;
        bus_o = '0;
    end

    // The clock stands still between pairs, so the idle level is set apart.
    task automatic level(input logic lv);
        clk_o <= lv;
        #80;
    endtask

    // One 160 ns period carries one pair, well under the fastest clock allowed.
    task automatic pair(input logic [SAMPLE_W-1:0] w1, input logic [SAMPLE_W-1:0] w2);
        bus_o <= w1;
        #40;
        clk_o <= ~clk_o;
        #40;
        bus_o <= w2;
        #40;
        clk_o <= ~clk_o;
        #40;
        bus_o <= ~w2;
    endtask
endmodule
`default_nettype wire

// ===== tb_dual_dac_cal_retimer_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
    begin \
        checks++; \
        if ((gt) !== (ex)) \
        begin \
            n_errors++; \
            $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); \
        end \
    end
module tb_dual_dac_cal_retimer_ctrl;
    localparam int         W   = 14;
    localparam logic [7:0] REV = 8'h5C; // Arbitrary value.
    logic                  ref_clk = 1'b0;
    logic                  reset_n = 1'b0;
    logic                  ce = 1'b1;
    logic                  sclk = 1'b1;
    logic                  cs_n = 1'b1;
    logic                  host_sdio = 1'b0;
    logic                  converter_clock = 1'b0;
    logic                  sdio_out, sdio_oe, sdio_line, sample_bus_clock;
    logic [W-1:0]          sample_bus, i_sample_r, q_sample_r, iw, qw;
    logic                  sample_valid_r, searching_r, srch_d = 1'b1;
    logic [1:0]            i_phase_used_r, q_phase_used_r, ai, aq;
    logic [7:0]            rd;
    int                    checks = 0, n_errors = 0, cyc = 0, rises = 0, k;
    ddc_pkg::ddc_reg_req_t rows [0:33] = '{
        '{1'b0, 5'h1F, REV}, '{1'b1, 5'h1F, 8'hFF},
        '{1'b0, 5'h1F, REV}, '{1'b0, 5'h0F, 8'h00},
        '{1'b1, 5'h10, 8'h05}, '{1'b0, 5'h10, 8'h05},
        '{1'b1, 5'h11, 8'h2A}, '{1'b0, 5'h11, 8'h2A},
        '{1'b1, 5'h12, 8'h08}, '{1'b0, 5'h0F, 8'h02},
        '{1'b0, 5'h12, 8'h00}, '{1'b1, 5'h11, 8'h00},
        '{1'b1, 5'h12, 8'h04}, '{1'b0, 5'h11, 8'h2A},
        '{1'b1, 5'h10, 8'h25}, '{1'b1, 5'h12, 8'h08},
        '{1'b0, 5'h0F, 8'h0A}, '{1'b1, 5'h12, 8'h01},
        '{1'b0, 5'h0F, 8'h08}, '{1'b1, 5'h10, 8'h05},
        '{1'b1, 5'h12, 8'h04}, '{1'b0, 5'h11, 8'h20},
        '{1'b1, 5'h12, 8'h02}, '{1'b0, 5'h0F, 8'h00},
        '{1'b1, 5'h12, 8'h10}, '{1'b0, 5'h0F, 8'hC5},
        '{1'b1, 5'h12, 8'h40}, '{1'b0, 5'h0F, 8'h85},
        '{1'b1, 5'h12, 8'h80}, '{1'b0, 5'h0F, 8'h05},
        '{1'b1, 5'h12, 8'h00}, '{1'b0, 5'h0F, 8'h05},
        '{1'b1, 5'h05, 8'hFF}, '{1'b0, 5'h05, 8'h00}
    };

    assign sdio_line = sdio_oe ? sdio_out : host_sdio;

    always #10 ref_clk = ~ref_clk;
    always #13 converter_clock = ~converter_clock;

    ddc_ctrl #(.SAMPLE_W(W), .REVISION_ID(REV)) u_dut (
        .ref_clk, .reset_n, .ce, .sclk, .cs_n, .sdio_in(sdio_line), .sdio_out,
        .sdio_oe, .sample_bus_clock, .sample_bus, .converter_clock, .i_sample_r,
        .q_sample_r, .sample_valid_r, .i_phase_used_r, .q_phase_used_r, .searching_r
    );
    ddc_link_src #(.SAMPLE_W(W)) u_src (
        .clk_o(sample_bus_clock),
        .bus_o(sample_bus)
    );

    task finish_test();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Host drives on the falling serial edge and takes read bits before the rising one.
    task xfer(input logic r, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {r, 2'h0, a, d};
        q = 8'h00;
        @(posedge ref_clk) cs_n <= 1'b0;
        for (int b = 15; b >= 0; b--)
        begin
            @(posedge ref_clk) sclk <= 1'b0;
            host_sdio <= f[b];
            repeat (5) @(posedge ref_clk);
            if (b < 8)
                q[b] = sdio_line;
            sclk <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
        @(posedge ref_clk) cs_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask

    always @(posedge ref_clk)
    begin
        srch_d <= searching_r;
        rises <= rises + int'(searching_r && !srch_d);
        cyc++;
        if (cyc == 30000)
        begin
            n_errors++;
            finish_test();
        end
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (140) @(posedge ref_clk);
        `CHK("searching", 1'b0, searching_r)
        $display("test reset done");
        foreach (rows[r])
        begin
            xfer(!rows[r].wr, rows[r].addr, rows[r].wdata, rd);
            if (!rows[r].wr)
                `CHK("register", rows[r].wdata, rd)
        end
        $display("test registers done");
        ai = i_phase_used_r;
        aq = q_phase_used_r;
        xfer(1'b0, 5'h14, 8'h07, rd);
        xfer(1'b1, 5'h14, 8'h00, rd);
        `CHK("forced field", 8'hC7, rd)
        `CHK("forced phases", 4'hF, {i_phase_used_r, q_phase_used_r})
        xfer(1'b0, 5'h14, 8'h01, rd);
        xfer(1'b1, 5'h14, 8'h00, rd);
        `CHK("auto field", {aq, 4'h0, ai}, rd)
        k = rises;
        xfer(1'b0, 5'h14, 8'h08, rd);
        repeat (140) @(posedge ref_clk);
        xfer(1'b0, 5'h14, 8'h08, rd);
        repeat (140) @(posedge ref_clk);
        `CHK("search count", k + 1, rises)
        `CHK("searching", 1'b0, searching_r)
        $display("test retimer done");
        xfer(1'b0, 5'h14, 8'h00, rd);
        xfer(1'b0, 5'h14, 8'h08, rd);
        ce <= 1'b0;
        repeat (200) @(posedge ref_clk);
        `CHK("frozen search", 1'b1, searching_r)
        ce <= 1'b1;
        repeat (140) @(posedge ref_clk);
        `CHK("thawed search", 1'b0, searching_r)
        $display("test enable done");
        for (int v = 0; v < 8; v++)
        begin
            xfer(1'b0, 5'h02, {v[2], 1'b0, v[0], v[1], 4'h0}, rd);
            u_src.level(v[0] == v[1] ? 1'b0 : 1'b1);
            iw = 14'h1234 + W'(v);
            qw = 14'h2ABC - W'(v);
            repeat (20) @(posedge ref_clk);
            u_src.pair(v[0] ? iw : qw, v[0] ? qw : iw);
            k = 0;
            while (sample_valid_r !== 1'b1 && k < 20)
            begin
                @(negedge ref_clk);
                k++;
            end
            `CHK("valid", 1'b1, sample_valid_r)
            `CHK("i sample", iw ^ {!v[2], 13'h0}, i_sample_r)
            `CHK("q sample", qw ^ {!v[2], 13'h0}, q_sample_r)
        end
        $display("test samples done");
        finish_test();
    end
endmodule
`undef CHK
`default_nettype wire
